//--- dv/cpu_side_model.sv
`timescale 1ns/1ps
module cpu_side_model (
  input wire logic clk_sys_i,
  output logic dp_we_o,
  output logic [regfile_pkg::SEL_W-1:0] dp_sel_o,
  output logic [2*regfile_pkg::DATA_W-1:0] dp_data_o,
  output logic [regfile_pkg::STEP_W-1:0] pc_step_o,
  output logic alu_upd_o,
  output logic alu_byte_o,
  output logic [regfile_pkg::DATA_W-1:0] alu_result_o,
  output logic alu_carry_o,
  output logic alu_overflow_o,
  output logic irq_req_o,
  output logic irq_maskable_o,
  output logic [regfile_pkg::PRIO_W-1:0] irq_prio_o,
  output logic irq_accept_o,
  output logic irq_hw_o,
  output logic trap_o,
  output logic [regfile_pkg::VEC_W-1:0] trap_vec_o
);
  import regfile_pkg::*;

  initial begin
    {dp_we_o, dp_sel_o, dp_data_o, pc_step_o, alu_upd_o, alu_byte_o, alu_result_o} = '0;
    {alu_carry_o, alu_overflow_o, irq_req_o, irq_maskable_o, irq_prio_o} = '0;
    {irq_accept_o, irq_hw_o, trap_o, trap_vec_o} = '0;
  end

  // Strobes last one cycle; the small delay lets the register updates land before the caller looks.
  task automatic drop();
    @(posedge clk_sys_i);
    {dp_we_o, alu_upd_o, irq_accept_o, trap_o} <= '0;
    #1;
  endtask

  task automatic dp_write(input logic [SEL_W-1:0] sel, input logic [31:0] data);
    @(posedge clk_sys_i);
    dp_we_o <= 1'b1;
    dp_sel_o <= sel;
    // The datapath never sets the debug flag and always writes zero above the flag field.
    dp_data_o <= (sel == SEL_FLAGS) ? (data & 32'h000007FD) : data;
    drop();
  endtask

  task automatic alu_op(input logic byte_op, input logic [15:0] res, input logic cy, input logic ov);
    @(posedge clk_sys_i);
    alu_upd_o <= 1'b1;
    alu_byte_o <= byte_op;
    alu_result_o <= res;
    alu_carry_o <= cy;
    alu_overflow_o <= ov;
    drop();
  endtask

  task automatic accept(input logic hw);
    @(posedge clk_sys_i);
    irq_accept_o <= 1'b1;
    irq_hw_o <= hw;
    drop();
  endtask

  task automatic trap(input logic [VEC_W-1:0] vec);
    @(posedge clk_sys_i);
    trap_o <= 1'b1;
    trap_vec_o <= vec;
    drop();
  endtask

  task automatic set_irq(input logic req, input logic mask, input logic [PRIO_W-1:0] prio);
    @(posedge clk_sys_i);
    irq_req_o <= req;
    irq_maskable_o <= mask;
    irq_prio_o <= prio;
    #1;
  endtask

  task automatic run_pc(input logic [STEP_W-1:0] step, input int n);
    @(posedge clk_sys_i);
    pc_step_o <= step;
    repeat (n) @(posedge clk_sys_i);
    pc_step_o <= '0;
    #1;
  endtask
endmodule

//--- dv/tb_cpu_regfile.sv
`timescale 1ns/1ps
module tb_cpu_regfile;
  import regfile_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [BUS_AW-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [BUS_DW-1:0] avs_writedata_i = '0;
  logic [BUS_BE_W-1:0] avs_byteenable_i = '0;
  logic [BUS_DW-1:0] avs_readdata_o;
  logic [2*DATA_W-1:0] dp_data_i, combined_address_pair_o;
  logic [DATA_W-1:0] alu_result_i, frame_base_o, static_base_o, sp_active_o;
  logic [ADDR_W-1:0] vector_table_base_o, program_counter_o;
  logic [SEL_W-1:0] dp_sel_i;
  logic [STEP_W-1:0] pc_step_i;
  logic [PRIO_W-1:0] irq_prio_i;
  logic [VEC_W-1:0] trap_vec_i;
  logic [FLAG_W-1:0] cpu_flags_o;
  logic avs_waitrequest_o, dp_we_i, alu_upd_i, alu_byte_i, alu_carry_i, alu_overflow_i, irq_req_i;
  logic irq_maskable_i, irq_accept_i, irq_hw_i, trap_i, bank_sel_o, irq_enable_o;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] rd;

  localparam logic [BUS_AW-1:0] OFS_TBL [8] = '{OFS_ADDR_ZERO, OFS_ADDR_ONE, OFS_FRAME, OFS_VECTOR,
    OFS_PROG, OFS_USER_SP, OFS_INT_SP, OFS_STATIC};
  localparam logic [31:0] MASK_TBL [8] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h000FFFFF,
    32'h000FFFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF};
  // Packed as byte mode, result, carry, overflow, expected arithmetic flag bits.
  localparam logic [29:0] ALU_TBL [6] = '{{1'h0, 16'h0000, 1'h1, 1'h0, 11'h005},
    {1'h0, 16'h8000, 1'h0, 1'h1, 11'h028}, {1'h0, 16'h0001, 1'h1, 1'h1, 11'h021},
    {1'h1, 16'h0100, 1'h0, 1'h0, 11'h004}, {1'h1, 16'h0080, 1'h0, 1'h0, 11'h008},
    {1'h1, 16'h7F7F, 1'h0, 1'h0, 11'h000}};
  // Packed as flags, request, maskable, priority, expected enable.
  localparam logic [16:0] IRQ_TBL [7] = '{{11'h340, 1'h1, 1'h1, 3'h4, 1'h1}, {11'h340, 1'h1, 1'h1, 3'h3, 1'h0},
    {11'h300, 1'h1, 1'h1, 3'h7, 1'h0}, {11'h300, 1'h1, 1'h0, 3'h4, 1'h1}, {11'h740, 1'h1, 1'h0, 3'h7, 1'h0},
    {11'h040, 1'h1, 1'h1, 3'h1, 1'h1}, {11'h040, 1'h0, 1'h1, 3'h7, 1'h0}};
  localparam logic [6:0] TRAP_TBL [3] = '{{6'h20, 1'h1}, {6'h1F, 1'h0}, {6'h00, 1'h0}};

  cpu_regfile uut (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .dp_we_i, .dp_sel_i, .dp_data_i, .pc_step_i, .alu_upd_i, .alu_byte_i,
    .alu_result_i, .alu_carry_i, .alu_overflow_i, .irq_req_i, .irq_maskable_i, .irq_prio_i, .irq_accept_i,
    .irq_hw_i, .trap_i, .trap_vec_i, .combined_address_pair_o, .frame_base_o, .static_base_o,
    .vector_table_base_o, .program_counter_o, .sp_active_o, .cpu_flags_o, .bank_sel_o, .irq_enable_o
  );

  cpu_side_model model (
    .clk_sys_i, .dp_we_o(dp_we_i), .dp_sel_o(dp_sel_i), .dp_data_o(dp_data_i), .pc_step_o(pc_step_i),
    .alu_upd_o(alu_upd_i), .alu_byte_o(alu_byte_i), .alu_result_o(alu_result_i), .alu_carry_o(alu_carry_i),
    .alu_overflow_o(alu_overflow_i), .irq_req_o(irq_req_i), .irq_maskable_o(irq_maskable_i),
    .irq_prio_o(irq_prio_i), .irq_accept_o(irq_accept_i), .irq_hw_o(irq_hw_i), .trap_o(trap_i),
    .trap_vec_o(trap_vec_i)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waitrequest is sampled as it stood just before each edge, so the request is released only after
  // the edge at which it was seen low.
  task automatic bus_xfer(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d,
                          input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    check("bus_answer", 32'(n < 50), 32'h00000001);
    #1;
  endtask

  task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    bus_xfer(1'b1, a, d, be);
  endtask

  task automatic rd_chk(input string what, input logic [BUS_AW-1:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h00000000, 4'hF);
    check(what, rd, exp);
  endtask

  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [29:0] a;
    logic [16:0] q;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk("flags_reset", OFS_FLAGS, 32'h00000000);
    check("irq_en_reset", 32'(irq_enable_o), 32'h00000000);
    bus_wr(6'h28, 32'hFFFFFFFF);
    rd_chk("unmapped", 6'h28, 32'h00000000);
    bus_wr(OFS_STATUS, 32'h00000003);
    rd_chk("status_ro", OFS_STATUS, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      bus_wr(OFS_TBL[i], 32'hFFFFFFFF);
      rd_chk("reg_width", OFS_TBL[i], MASK_TBL[i]);
    end
    check("vector_out", 32'(vector_table_base_o), 32'h000FFFFF);
    check("static_out", 32'(static_base_o), 32'h0000FFFF);
    bus_wr(OFS_FRAME, 32'h00000012, 4'h1);
    check("frame_lane", 32'(frame_base_o), 32'h0000FF12);
    bus_wr(OFS_ADDR_ZERO, 32'h00001234);
    bus_wr(OFS_ADDR_ONE, 32'h0000ABCD);
    check("pair_out", combined_address_pair_o, 32'hABCD1234);
    model.dp_write(SEL_PAIR, 32'h87654321);
    rd_chk("pair_low", OFS_ADDR_ZERO, 32'h00004321);
    rd_chk("pair_high", OFS_ADDR_ONE, 32'h00008765);
    // The counter wraps at its full 20-bit width.
    bus_wr(OFS_PROG, 32'h000FFFFE);
    model.run_pc(3'h3, 5);
    check("pc_step", 32'(program_counter_o), 32'h0000000D);
    bus_wr(OFS_FLAGS, 32'h000007D0);
    rd_chk("flags_rw", OFS_FLAGS, 32'h000007D0);
    for (int i = 0; i < 6; i++) begin
      a = ALU_TBL[i];
      model.alu_op(a[29], a[28:13], a[12], a[11]);
      check("alu_flags", 32'(cpu_flags_o), 32'(a[10:0] | 11'h7D0));
    end
    for (int b = 1; b >= 0; b--) begin
      model.dp_write(SEL_FLAGS, 32'(b) << FLAG_BANK);
      check("bank_sel", 32'(bank_sel_o), 32'(b));
    end
    bus_wr(OFS_USER_SP, 32'h00001111);
    bus_wr(OFS_INT_SP, 32'h00002222);
    model.dp_write(SEL_FLAGS, 32'h000000C0);
    tick();
    check("sp_user", 32'(sp_active_o), 32'h00001111);
    rd_chk("status_user", OFS_STATUS, 32'h00000001);
    model.dp_write(SEL_ACTIVE_SP, 32'h00005555);
    rd_chk("active_sp_wr", OFS_USER_SP, 32'h00005555);
    model.accept(1'b0);
    check("accept_sw", 32'(cpu_flags_o), 32'h00000080);
    model.dp_write(SEL_FLAGS, 32'h000000C0);
    model.accept(1'b1);
    check("accept_hw", 32'(cpu_flags_o), 32'h00000000);
    tick();
    check("sp_int", 32'(sp_active_o), 32'h00002222);
    for (int i = 0; i < 3; i++) begin
      model.dp_write(SEL_FLAGS, 32'h00000080);
      model.trap(TRAP_TBL[i][6:1]);
      check("trap_ustk", 32'(cpu_flags_o[FLAG_USTK]), 32'(TRAP_TBL[i][0]));
    end
    for (int i = 0; i < 7; i++) begin
      q = IRQ_TBL[i];
      model.set_irq(q[5], q[4], q[3:1]);
      model.dp_write(SEL_FLAGS, 32'(q[16:6]));
      tick();
      check("prio_level", 32'(cpu_flags_o[10:8]), 32'(q[16:14]));
      check("irq_enable", 32'(irq_enable_o), 32'(q[0]));
    end
    // Select codes 0 to 7 follow the same register order as the bus offset table.
    for (int i = 0; i < 8; i++) begin
      model.dp_write(SEL_W'(i), 32'h0005A5C3);
      rd_chk("dp_width", OFS_TBL[i], 32'h0005A5C3 & MASK_TBL[i]);
    end
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    check("flags_rerst", 32'(cpu_flags_o), 32'h00000000);
    check("pair_rerst", combined_address_pair_o, 32'h00000000);
    end_sim();
  end
endmodule

//--- src/cpu_regfile.sv
`timescale 1ns/1ps
module cpu_regfile #(
  parameter logic [regfile_pkg::ADDR_W-1:0] PC_RESET = 20'h00000,
  parameter logic [regfile_pkg::ADDR_W-1:0] VECTOR_RESET = 20'h00000,
  parameter int ADDR_W = regfile_pkg::ADDR_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [regfile_pkg::BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [regfile_pkg::BUS_DW-1:0] avs_writedata_i,
  input wire logic [regfile_pkg::BUS_BE_W-1:0] avs_byteenable_i,
  output logic [regfile_pkg::BUS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic dp_we_i,
  input wire logic [regfile_pkg::SEL_W-1:0] dp_sel_i,
  input wire logic [2*regfile_pkg::DATA_W-1:0] dp_data_i,
  input wire logic [regfile_pkg::STEP_W-1:0] pc_step_i,
  input wire logic alu_upd_i,
  input wire logic alu_byte_i,
  input wire logic [regfile_pkg::DATA_W-1:0] alu_result_i,
  input wire logic alu_carry_i,
  input wire logic alu_overflow_i,
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [regfile_pkg::PRIO_W-1:0] irq_prio_i,
  input wire logic irq_accept_i,
  input wire logic irq_hw_i,
  input wire logic trap_i,
  input wire logic [regfile_pkg::VEC_W-1:0] trap_vec_i,
  output logic [2*regfile_pkg::DATA_W-1:0] combined_address_pair_o,
  output logic [regfile_pkg::DATA_W-1:0] frame_base_o,
  output logic [regfile_pkg::DATA_W-1:0] static_base_o,
  output logic [regfile_pkg::ADDR_W-1:0] vector_table_base_o,
  output logic [regfile_pkg::ADDR_W-1:0] program_counter_o,
  output logic [regfile_pkg::DATA_W-1:0] sp_active_o,
  output logic [regfile_pkg::FLAG_W-1:0] cpu_flags_o,
  output logic bank_sel_o,
  output logic irq_enable_o
);
  import regfile_pkg::*;

  if (ADDR_W != regfile_pkg::ADDR_W) begin : g_bad_width
    $error("cpu_regfile supports only the fixed program address width");
  end

  logic [DATA_W-1:0] addr_zero_q, addr_zero_d;
  logic [DATA_W-1:0] addr_one_q, addr_one_d;
  logic [DATA_W-1:0] frame_base_q, frame_base_d;
  logic [DATA_W-1:0] static_base_q, static_base_d;
  logic [DATA_W-1:0] user_sp_q, user_sp_d;
  logic [DATA_W-1:0] int_sp_q, int_sp_d;
  logic [ADDR_W-1:0] vector_base_q, vector_base_d;
  logic [ADDR_W-1:0] prog_cnt_q, prog_cnt_d;
  logic [FLAG_W-1:0] flags_q, flags_d;
  logic [DATA_W-1:0] sp_active_q;
  logic irq_en_q;
  logic wait_q;
  logic [BUS_DW-1:0] rdata_q;
  logic [BUS_DW-1:0] rd_word;
  logic [BUS_DW-1:0] wr_word;
  logic bus_wr_take;
  logic bus_rd_start;
  logic alu_zero;
  logic alu_neg;
  logic flag_ext_wr;
  logic irq_allowed;

  // Merges the enabled byte lanes of a write over the current register value.
  function automatic logic [BUS_DW-1:0] lane_merge(input logic [BUS_DW-1:0] old_w,
                                                   input logic [BUS_DW-1:0] new_w,
                                                   input logic [BUS_BE_W-1:0] be);
    logic [BUS_DW-1:0] res;
    res = old_w;
    for (int i = 0; i < BUS_BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Stack select routes stack accesses; used by the datapath write path, the status read and the output.
  function automatic logic use_user_sp(input logic [FLAG_W-1:0] flag_word);
    return flag_word[FLAG_USTK];
  endfunction

  assign bus_wr_take = avs_write_i && !wait_q;
  assign bus_rd_start = avs_read_i && wait_q;
  assign alu_zero = alu_byte_i ? (alu_result_i[BYTE_MSB:0] == 8'h00) : (alu_result_i == WORD_RESET);
  assign alu_neg = alu_byte_i ? alu_result_i[BYTE_MSB] : alu_result_i[DATA_W-1];
  assign flag_ext_wr = (dp_we_i && dp_sel_i == SEL_FLAGS) || (bus_wr_take && avs_address_i == OFS_FLAGS);

  // A request passes only when it outranks the current level and, if maskable, interrupts are on.
  assign irq_allowed = irq_req_i && (!irq_maskable_i || flags_q[FLAG_IEN]) &&
                       (irq_prio_i > flags_q[FLAG_PRIO_LO +: PRIO_W]);

  // Read mux, shared by bus reads and by the byte-lane merge of bus writes.
  // Bits above a register's width read as zero, reserved flag area included.
  always_comb begin
    rd_word = '0;
    unique case (avs_address_i)
      OFS_ADDR_ZERO: rd_word[DATA_W-1:0] = addr_zero_q;
      OFS_ADDR_ONE: rd_word[DATA_W-1:0] = addr_one_q;
      OFS_FRAME: rd_word[DATA_W-1:0] = frame_base_q;
      OFS_VECTOR: rd_word[ADDR_W-1:0] = vector_base_q;
      OFS_PROG: rd_word[ADDR_W-1:0] = prog_cnt_q;
      OFS_USER_SP: rd_word[DATA_W-1:0] = user_sp_q;
      OFS_INT_SP: rd_word[DATA_W-1:0] = int_sp_q;
      OFS_STATIC: rd_word[DATA_W-1:0] = static_base_q;
      OFS_FLAGS: rd_word[FLAG_W-1:0] = flags_q;
      OFS_STATUS: begin
        rd_word[STAT_USTK] = use_user_sp(flags_q);
        rd_word[STAT_IRQ_EN] = irq_en_q;
      end
      default: rd_word = '0;
    endcase
  end

  assign wr_word = lane_merge(rd_word, avs_writedata_i, avs_byteenable_i);

  // Next-state of the register set. Later assignments win, so the order sets the
  // priority: bus, then datapath, then ALU flags, then interrupt and trap effects.
  // ALU, interrupt and trap effects therefore never lose to a software write in the same cycle.
  always_comb begin
    addr_zero_d = addr_zero_q;
    addr_one_d = addr_one_q;
    frame_base_d = frame_base_q;
    static_base_d = static_base_q;
    user_sp_d = user_sp_q;
    int_sp_d = int_sp_q;
    vector_base_d = vector_base_q;
    prog_cnt_d = prog_cnt_q + ADDR_W'(pc_step_i);
    flags_d = flags_q;
    if (bus_wr_take) begin
      unique case (avs_address_i)
        OFS_ADDR_ZERO: addr_zero_d = wr_word[DATA_W-1:0];
        OFS_ADDR_ONE: addr_one_d = wr_word[DATA_W-1:0];
        OFS_FRAME: frame_base_d = wr_word[DATA_W-1:0];
        OFS_VECTOR: vector_base_d = wr_word[ADDR_W-1:0];
        OFS_PROG: prog_cnt_d = wr_word[ADDR_W-1:0];
        OFS_USER_SP: user_sp_d = wr_word[DATA_W-1:0];
        OFS_INT_SP: int_sp_d = wr_word[DATA_W-1:0];
        OFS_STATIC: static_base_d = wr_word[DATA_W-1:0];
        OFS_FLAGS: flags_d = wr_word[FLAG_W-1:0];
        default: begin
        end
      endcase
    end
    if (dp_we_i) begin
      unique case (dp_sel_i)
        SEL_ADDR_ZERO: addr_zero_d = dp_data_i[DATA_W-1:0];
        SEL_ADDR_ONE: addr_one_d = dp_data_i[DATA_W-1:0];
        SEL_FRAME: frame_base_d = dp_data_i[DATA_W-1:0];
        SEL_VECTOR: vector_base_d = dp_data_i[ADDR_W-1:0];
        SEL_PROG: prog_cnt_d = dp_data_i[ADDR_W-1:0];
        SEL_USER_SP: user_sp_d = dp_data_i[DATA_W-1:0];
        SEL_INT_SP: int_sp_d = dp_data_i[DATA_W-1:0];
        SEL_STATIC: static_base_d = dp_data_i[DATA_W-1:0];
        SEL_FLAGS: flags_d = dp_data_i[FLAG_W-1:0];
        SEL_PAIR: begin
          addr_zero_d = dp_data_i[DATA_W-1:0];
          addr_one_d = dp_data_i[2*DATA_W-1:DATA_W];
        end
        SEL_ACTIVE_SP: begin
          if (use_user_sp(flags_q)) begin
            user_sp_d = dp_data_i[DATA_W-1:0];
          end else begin
            int_sp_d = dp_data_i[DATA_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (alu_upd_i) begin
      flags_d[FLAG_CARRY] = alu_carry_i;
      flags_d[FLAG_ZERO] = alu_zero;
      flags_d[FLAG_SIGN] = alu_neg;
      flags_d[FLAG_OVFL] = alu_overflow_i;
    end
    if (irq_accept_i) begin
      flags_d[FLAG_IEN] = 1'b0;
    end
    if ((irq_accept_i && irq_hw_i) || (trap_i && trap_vec_i <= TRAP_USTK_MAX)) begin
      flags_d[FLAG_USTK] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr_zero_q <= WORD_RESET;
      addr_one_q <= WORD_RESET;
      frame_base_q <= WORD_RESET;
      static_base_q <= WORD_RESET;
      user_sp_q <= WORD_RESET;
      int_sp_q <= WORD_RESET;
    end else begin
      addr_zero_q <= addr_zero_d;
      addr_one_q <= addr_one_d;
      frame_base_q <= frame_base_d;
      static_base_q <= static_base_d;
      user_sp_q <= user_sp_d;
      int_sp_q <= int_sp_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      vector_base_q <= VECTOR_RESET;
      prog_cnt_q <= PC_RESET;
    end else begin
      vector_base_q <= vector_base_d;
      prog_cnt_q <= prog_cnt_d;
    end
  end

  // Flags change only on the edge that completes the affecting event.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // The active pointer copy is loaded from next values so it never lags the select.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sp_active_q <= WORD_RESET;
      irq_en_q <= 1'b0;
    end else begin
      sp_active_q <= use_user_sp(flags_d) ? user_sp_d : int_sp_d;
      irq_en_q <= irq_allowed;
    end
  end

  // Every access takes exactly one wait cycle; read data is captured in that cycle,
  // so it stands stable at the edge where waitrequest is low.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (bus_rd_start) begin
      rdata_q <= rd_word;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign combined_address_pair_o = {addr_one_q, addr_zero_q};
  assign frame_base_o = frame_base_q;
  assign static_base_o = static_base_q;
  assign vector_table_base_o = vector_base_q;
  assign program_counter_o = prog_cnt_q;
  assign sp_active_o = sp_active_q;
  assign cpu_flags_o = flags_q;
  assign bank_sel_o = flags_q[FLAG_BANK];
  assign irq_enable_o = irq_en_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_carry;
    alu_upd_i && !flag_ext_wr |=> flags_q[FLAG_CARRY] == $past(alu_carry_i);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag not captured");

  property p_zero;
    alu_upd_i && !flag_ext_wr |=> flags_q[FLAG_ZERO] ==
      ($past(alu_byte_i) ? ($past(alu_result_i[BYTE_MSB:0]) == 8'h00) : ($past(alu_result_i) == 16'h0000));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sign;
    alu_upd_i && !flag_ext_wr |=> flags_q[FLAG_SIGN] ==
      ($past(alu_byte_i) ? $past(alu_result_i[BYTE_MSB]) : $past(alu_result_i[DATA_W-1]));
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  property p_ovfl;
    alu_upd_i && !flag_ext_wr |=> flags_q[FLAG_OVFL] == $past(alu_overflow_i);
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow flag wrong");

  property p_ien_clear;
    irq_accept_i |=> !flags_q[FLAG_IEN] && !cpu_flags_o[FLAG_IEN];
  endproperty
  a_ien_clear: assert property (p_ien_clear) else $error("interrupt enable not cleared");

  property p_ien_hold;
    !flag_ext_wr && !irq_accept_i |=> $stable(cpu_flags_o[FLAG_IEN]);
  endproperty
  a_ien_hold: assert property (p_ien_hold) else $error("interrupt enable changed by itself");

  property p_prio_hold;
    !flag_ext_wr |=> $stable(cpu_flags_o[FLAG_PRIO_LO +: PRIO_W]);
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priority level changed by itself");

  property p_ustk_clear;
    (irq_accept_i && irq_hw_i) || (trap_i && trap_vec_i < 6'h20) |=> !flags_q[FLAG_USTK];
  endproperty
  a_ustk_clear: assert property (p_ustk_clear) else $error("stack select not cleared");

  property p_ustk_keep;
    trap_i && trap_vec_i > 6'h1F && !irq_accept_i && !flag_ext_wr |=> $stable(flags_q[FLAG_USTK]);
  endproperty
  a_ustk_keep: assert property (p_ustk_keep) else $error("high trap changed stack select");

  property p_irq_gate;
    ##1 irq_enable_o == ($past(irq_req_i) && ($past(!irq_maskable_i) || $past(flags_q[FLAG_IEN]))
                         && ($past(irq_prio_i) > $past(flags_q[FLAG_PRIO_LO +: PRIO_W])));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_sp_select;
    sp_active_o == (flags_q[FLAG_USTK] ? user_sp_q : int_sp_q);
  endproperty
  a_sp_select: assert property (p_sp_select) else $error("active stack pointer wrong");

  property p_pc_step;
    !dp_we_i && !(avs_write_i && !avs_waitrequest_o) |=>
      program_counter_o == $past(program_counter_o) + ADDR_W'($past(pc_step_i));
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");

  property p_dp_frame;
    dp_we_i && dp_sel_i == SEL_FRAME |=> frame_base_o == $past(dp_data_i[DATA_W-1:0]);
  endproperty
  a_dp_frame: assert property (p_dp_frame) else $error("frame base write wrong");

  property p_flags_read;
    avs_read_i && avs_waitrequest_o && avs_address_i == OFS_FLAGS |=>
      avs_readdata_o == BUS_DW'($past(cpu_flags_o));
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag register read wrong");

  property p_flags_write;
    avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_FLAGS && avs_byteenable_i == 4'hF &&
      !dp_we_i && !alu_upd_i && !irq_accept_i && !trap_i |=> cpu_flags_o == $past(avs_writedata_i[FLAG_W-1:0]);
  endproperty
  a_flags_write: assert property (p_flags_write) else $error("flag register write wrong");

  property p_bank;
    bank_sel_o == cpu_flags_o[FLAG_BANK];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");

  property p_pair;
    dp_we_i && dp_sel_i == SEL_PAIR && !bus_wr_take |=> combined_address_pair_o == $past(dp_data_i);
  endproperty
  a_pair: assert property (p_pair) else $error("address pair write wrong");

  property p_bus_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait sequence wrong");

  property p_bus_idle;
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("waitrequest low without a request");

  c_irq_accept: cover property (irq_accept_i && irq_hw_i ##1 !flags_q[FLAG_USTK]);
  c_trap_high: cover property (trap_i && trap_vec_i > TRAP_USTK_MAX);
  c_trap_low: cover property (trap_i && trap_vec_i < 6'h20);
  c_bus_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_pair_write: cover property (dp_we_i && dp_sel_i == SEL_PAIR);
endmodule

//--- src/regfile_pkg.sv
package regfile_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;
  localparam int FLAG_W = 11;
  localparam int BUS_AW = 6;
  localparam int BUS_DW = 32;
  localparam int BUS_BE_W = 4;
  localparam int SEL_W = 4;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 6;
  localparam int STEP_W = 3;

  // Byte offsets on the register bus.
  localparam logic [BUS_AW-1:0] OFS_ADDR_ZERO = 6'h00;
  localparam logic [BUS_AW-1:0] OFS_ADDR_ONE = 6'h04;
  localparam logic [BUS_AW-1:0] OFS_FRAME = 6'h08;
  localparam logic [BUS_AW-1:0] OFS_VECTOR = 6'h0C;
  localparam logic [BUS_AW-1:0] OFS_PROG = 6'h10;
  localparam logic [BUS_AW-1:0] OFS_USER_SP = 6'h14;
  localparam logic [BUS_AW-1:0] OFS_INT_SP = 6'h18;
  localparam logic [BUS_AW-1:0] OFS_STATIC = 6'h1C;
  localparam logic [BUS_AW-1:0] OFS_FLAGS = 6'h20;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 6'h24;

  // Datapath register select codes.
  localparam logic [SEL_W-1:0] SEL_ADDR_ZERO = 4'h0;
  localparam logic [SEL_W-1:0] SEL_ADDR_ONE = 4'h1;
  localparam logic [SEL_W-1:0] SEL_FRAME = 4'h2;
  localparam logic [SEL_W-1:0] SEL_VECTOR = 4'h3;
  localparam logic [SEL_W-1:0] SEL_PROG = 4'h4;
  localparam logic [SEL_W-1:0] SEL_USER_SP = 4'h5;
  localparam logic [SEL_W-1:0] SEL_INT_SP = 4'h6;
  localparam logic [SEL_W-1:0] SEL_STATIC = 4'h7;
  localparam logic [SEL_W-1:0] SEL_FLAGS = 4'h8;
  localparam logic [SEL_W-1:0] SEL_PAIR = 4'hA;
  localparam logic [SEL_W-1:0] SEL_ACTIVE_SP = 4'hB;

  // Flag register field positions.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DEBUG = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGN = 3;
  localparam int FLAG_BANK = 4;
  localparam int FLAG_OVFL = 5;
  localparam int FLAG_IEN = 6;
  localparam int FLAG_USTK = 7;
  localparam int FLAG_PRIO_LO = 8;

  localparam int STAT_USTK = 0;
  localparam int STAT_IRQ_EN = 1;
  localparam int BYTE_MSB = 7;

  localparam logic [VEC_W-1:0] TRAP_USTK_MAX = 6'h1F;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 11'h000;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
endpackage
